/* File: hdl/otp_gen.sv */
// Purpose: converter and link test pattern generator with Wishbone regs
// Assumes: one clock; partner keeps the host-side sequencing
// Notes: single-cycle ack; link sequences advance one step per clock, converter PN sequences 14 steps
//
// The address map and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module otp_gen (
    // clock and reset
    input wire logic CLOCK,
    input wire logic NRST,
    // wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [11:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // converter core samples, channel A and B
    input wire otp_pkg::otp_pair_s CORE_IN,
    // downconverter outputs toward formatter
    input wire otp_pkg::otp_pair_s DDC_IN [4],
    // formatted outputs
    output otp_pkg::otp_pair_s ADC_OUT,
    output otp_pkg::otp_pair_s DDC_OUT [4],
    output logic CORE_CUT,
    // link injection
    output logic [15:0] LINK_WORD,
    output logic [1:0] LINK_POINT,
    output logic LINK_INJECT,
    output logic LINK_TPORT
);
    ////////////////////////////////////////////////////////////////////
    logic [7:0] adc_test_q, if_test_q, tport_q;
    logic [7:0] ddc_q [4];
    logic [7:0] user_q [8];
    logic acc, wr;
    logic [15:0] uw [4];
    assign acc = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign wr = acc && WB_WE_I && WB_SEL_I[0];
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            uw[k] = {user_q[2*k+1], user_q[2*k]};
        end
    end

    // soft reset at config address puts every test control back to off
    logic soft_rst;
    assign soft_rst = wr && WB_ADR_I == otp_pkg::A_CONFIG &&
                      WB_DAT_I[7:0] == otp_pkg::SOFT_RESET_VAL;

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            adc_test_q <= 8'h00;
            if_test_q <= 8'h00;
            tport_q <= 8'h00;
            for (int k = 0; k < 4; k++) ddc_q[k] <= 8'h00;
            for (int k = 0; k < 8; k++) user_q[k] <= 8'h00;
        end else if (soft_rst) begin
            adc_test_q <= 8'h00;
            if_test_q <= 8'h00;
            tport_q <= 8'h00;
            for (int k = 0; k < 4; k++) ddc_q[k] <= 8'h00;
        end else if (wr) begin
            case (WB_ADR_I)
                otp_pkg::A_ADC_TEST: adc_test_q <= WB_DAT_I[7:0];
                otp_pkg::A_IF_TEST: if_test_q <= WB_DAT_I[7:0];
                otp_pkg::A_TPORT: tport_q <= WB_DAT_I[7:0];
                otp_pkg::A_DDC0: ddc_q[0] <= WB_DAT_I[7:0];
                otp_pkg::A_DDC1: ddc_q[1] <= WB_DAT_I[7:0];
                otp_pkg::A_DDC2: ddc_q[2] <= WB_DAT_I[7:0];
                otp_pkg::A_FOURTH_DOWN_CONVERTER: ddc_q[3] <= WB_DAT_I[7:0];
                default: begin
                    if (WB_ADR_I >= otp_pkg::A_USER0 &&
                        WB_ADR_I <= otp_pkg::A_USER7) begin
                        user_q[3'(WB_ADR_I - otp_pkg::A_USER0)] <=
                            WB_DAT_I[7:0];
                    end
                end
            endcase
        end
    end

    // config self-clears, so it always reads zero
    logic [31:0] rd_d;
    logic [1:0] uidx_q, iidx_q;
    logic usr_done_q, if_done_q;
    always_comb begin
        rd_d = 32'h0000_0000;
        case (WB_ADR_I)
            otp_pkg::A_ADC_TEST: rd_d[7:0] = adc_test_q;
            otp_pkg::A_IF_TEST: rd_d[7:0] = if_test_q;
            otp_pkg::A_TPORT: rd_d[7:0] = tport_q;
            otp_pkg::A_DDC0: rd_d[7:0] = ddc_q[0];
            otp_pkg::A_DDC1: rd_d[7:0] = ddc_q[1];
            otp_pkg::A_DDC2: rd_d[7:0] = ddc_q[2];
            otp_pkg::A_FOURTH_DOWN_CONVERTER: rd_d[7:0] = ddc_q[3];
            otp_pkg::A_STATUS:
                rd_d[7:0] = {2'b00, if_done_q, usr_done_q,
                             iidx_q, uidx_q};
            default: begin
                if (WB_ADR_I >= otp_pkg::A_USER0 &&
                    WB_ADR_I <= otp_pkg::A_USER7) begin
                    rd_d[7:0] = user_q[3'(WB_ADR_I - otp_pkg::A_USER0)];
                end
            end
        endcase
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else begin
            WB_ACK_O <= acc;
            WB_DAT_O <= acc ? rd_d : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // converter-side generators
    logic [3:0] amode, amode_last_q;
    logic arestart, pn_rst;
    assign amode = adc_test_q[3:0];
    // restart sequences whenever a mode is newly chosen
    assign arestart = amode != amode_last_q;
    assign pn_rst = adc_test_q[otp_pkg::B_PN_RST_LO] ||
                    adc_test_q[otp_pkg::B_PN_RST_HI];
    logic [22:0] apl_q;
    logic [8:0] aps_q;
    logic [13:0] aramp_q;
    logic aph_q;
    logic [13:0] apl_w, aps_w;
    // long-sequence sample is the 14 newest bits, short one the 9-bit register plus its top 5 bits; a Galois tap style is avoided
    // so the sample equals the register window the serial form would show
    function automatic logic [22:0] step23(input logic [22:0] s);
        logic [22:0] r;
        r = s;
        for (int b = 0; b < 14; b++) r = {r[21:0], r[22] ^ r[17]};
        return r;
    endfunction : step23
    function automatic logic [8:0] step9(input logic [8:0] s, input int n);
        logic [8:0] r;
        r = s;
        for (int b = 0; b < n; b++) r = {r[7:0], r[8] ^ r[4]};
        return r;
    endfunction : step9
    assign apl_w = apl_q[13:0];
    assign aps_w = {aps_q, aps_q[8:4]};

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            amode_last_q <= 4'h0;
            apl_q <= 23'h000000;
            aps_q <= 9'h000;
            aramp_q <= 14'h0000;
            aph_q <= 1'b0;
            uidx_q <= 2'b00;
            usr_done_q <= 1'b0;
        end else begin
            amode_last_q <= amode;
            if (arestart || pn_rst) begin
                apl_q <= otp_pkg::SEED23;
                aps_q <= otp_pkg::SEED9;
            end else begin
                apl_q <= step23(apl_q);
                aps_q <= step9(aps_q, 14);
            end
            if (arestart) begin
                aramp_q <= 14'h0000;
                aph_q <= 1'b0;
                uidx_q <= 2'b00;
                usr_done_q <= 1'b0;
            end else begin
                aramp_q <= aramp_q + 14'h0001;
                aph_q <= ~aph_q;
                uidx_q <= uidx_q + 2'b01;
                if (uidx_q == 2'b11) usr_done_q <= 1'b1;
            end
        end
    end

    logic [13:0] apat;
    always_comb begin
        case (amode)
            otp_pkg::C_MID: apat = 14'h0000;
            otp_pkg::C_PFS: apat = 14'h1FFF;
            otp_pkg::C_NFS: apat = 14'h2000;
            otp_pkg::C_CHK: apat = aph_q ? 14'h2AAA : 14'h1555;
            otp_pkg::C_PNL: apat = apl_w;
            otp_pkg::C_PNS: apat = aps_w;
            otp_pkg::C_TOG: apat = aph_q ? 14'h3FFF : 14'h0000;
            otp_pkg::C_RMP: apat = aramp_q;
            otp_pkg::C_USR: begin
                // single mode flushes zeros after four words
                if (adc_test_q[otp_pkg::B_USER_SINGLE] && usr_done_q)
                    apat = 14'h0000;
                else
                    apat = uw[uidx_q][15:2];
            end
            default: apat = 14'h0000;
        endcase
    end

    logic atest;
    assign atest = amode != otp_pkg::C_OFF;
    assign CORE_CUT = atest;

    // analog input is ignored purely by muxing; the clock keeps running
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            ADC_OUT <= '0;
        end else if (atest) begin
            ADC_OUT <= '{i: apat, q: apat};
        end else begin
            ADC_OUT <= CORE_IN;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_ddc
            logic ti, tq;
            // host arms each downconverter itself; we obey its bits, except the fourth's Q bit, which is ignored
            assign ti = atest && ddc_q[g][otp_pkg::B_DDC_TEST_I];
            assign tq = atest && (g != 3) &&
                        ddc_q[g][otp_pkg::B_DDC_TEST_Q];
            always_ff @(posedge CLOCK or negedge NRST) begin
                if (!NRST) begin
                    DDC_OUT[g] <= '0;
                end else begin
                    DDC_OUT[g].i <= ti ? apat : DDC_IN[g].i;
                    DDC_OUT[g].q <= tq ? apat : DDC_IN[g].q;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // link-side generators
    logic [3:0] imode, imode_last_q;
    logic [1:0] ipoint;
    logic irestart;
    assign imode = if_test_q[3:0];
    assign ipoint = if_test_q[5:4];
    assign irestart = imode != imode_last_q;
    logic [30:0] p31_q;
    logic [22:0] p23_q;
    logic [14:0] p15_q;
    logic [8:0] p9_q;
    logic [6:0] p7_q;
    logic [15:0] iramp_q;
    logic iph_q;

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            imode_last_q <= 4'h0;
            p31_q <= 31'h0;
            p23_q <= 23'h0;
            p15_q <= 15'h0;
            p9_q <= 9'h0;
            p7_q <= 7'h0;
            iramp_q <= 16'h0000;
            iph_q <= 1'b0;
            iidx_q <= 2'b00;
            if_done_q <= 1'b0;
        end else begin
            imode_last_q <= imode;
            if (irestart) begin
                p31_q <= otp_pkg::SEED31;
                p23_q <= otp_pkg::SEED23;
                p15_q <= otp_pkg::SEED15;
                p9_q <= otp_pkg::SEED9;
                p7_q <= otp_pkg::SEED7;
                iramp_q <= 16'h0000;
                iph_q <= 1'b0;
                iidx_q <= 2'b00;
                if_done_q <= 1'b0;
            end else begin
                p31_q <= {p31_q[29:0], p31_q[30] ^ p31_q[27]};
                p23_q <= {p23_q[21:0], p23_q[22] ^ p23_q[17]};
                p15_q <= {p15_q[13:0], p15_q[14] ^ p15_q[13]};
                p9_q <= {p9_q[7:0], p9_q[8] ^ p9_q[4]};
                p7_q <= {p7_q[5:0], p7_q[6] ^ p7_q[5]};
                iramp_q <= iramp_q + 16'h0001;
                iph_q <= ~iph_q;
                iidx_q <= iidx_q + 2'b01;
                if (iidx_q == 2'b11) if_done_q <= 1'b1;
            end
        end
    end

    // word width shrinks with injection point: 16, 10 or 8 bits
    logic [15:0] iword, mask;
    always_comb begin
        case (ipoint)
            2'b01: mask = 16'h03FF;
            2'b10: mask = 16'h00FF;
            default: mask = 16'hFFFF;
        endcase
        case (imode)
            otp_pkg::I_ALT: iword = iph_q ? 16'hAAAA : 16'h5555;
            otp_pkg::I_TOG: iword = iph_q ? 16'hFFFF : 16'h0000;
            otp_pkg::I_PN31: iword = p31_q[15:0];
            otp_pkg::I_PN23: iword = p23_q[15:0];
            otp_pkg::I_PN15: iword = p15_q[15:0];
            otp_pkg::I_PN9: iword = {7'h00, p9_q};
            otp_pkg::I_PN7: iword = {9'h000, p7_q};
            otp_pkg::I_RMP: iword = iramp_q;
            otp_pkg::I_UREP: begin
                iword = uw[iidx_q] >> (ipoint == 2'b01 ? 6 :
                        ipoint == 2'b10 ? 8 : 0);
            end
            otp_pkg::I_USNG: begin
                iword = if_done_q ? 16'h0000 : uw[iidx_q] >>
                        (ipoint == 2'b01 ? 6 :
                         ipoint == 2'b10 ? 8 : 0);
            end
            default: iword = 16'h0000;
        endcase
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            LINK_WORD <= 16'h0000;
            LINK_POINT <= 2'b00;
            LINK_INJECT <= 1'b0;
            LINK_TPORT <= 1'b0;
        end else begin
            LINK_WORD <= iword & mask;
            LINK_POINT <= ipoint;
            LINK_INJECT <= imode != otp_pkg::C_OFF &&
                           ipoint != 2'b11;
            LINK_TPORT <= tport_q[otp_pkg::B_TPORT_EN];
        end
    end

    ////////////////////////////////////////////////////////////////////
    a_ack_one: assert property (@(posedge CLOCK) disable iff (!NRST)
        WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
    a_ack_req: assert property (@(posedge CLOCK) disable iff (!NRST)
        acc |=> WB_ACK_O) else $error("request not acked");
    a_cut_core: assert property (@(posedge CLOCK) disable iff (!NRST)
        atest && amode == otp_pkg::C_PFS |=> ADC_OUT.i == 14'h1FFF)
        else $error("pattern not routed");
    a_pass_core: assert property (@(posedge CLOCK) disable iff (!NRST)
        !atest |=> ADC_OUT == $past(CORE_IN))
        else $error("normal path broken");
    a_pn_reset: assert property (@(posedge CLOCK) disable iff (!NRST)
        pn_rst |=> apl_q == otp_pkg::SEED23)
        else $error("pn reset missed");
    a_ramp_step: assert property (@(posedge CLOCK) disable iff (!NRST)
        !arestart ##1 !arestart |-> aramp_q == $past(aramp_q) + 14'h0001)
        else $error("ramp not incrementing");
    a_fourth_down_converter_noq: assert property (@(posedge CLOCK) disable iff (!NRST)
        1'b1 |=> DDC_OUT[3].q == $past(DDC_IN[3].q))
        else $error("fourth converter q patterned");
    a_single_zero: assert property (@(posedge CLOCK) disable iff (!NRST)
        imode == otp_pkg::I_USNG && !irestart ##4 imode == otp_pkg::I_USNG
        && !irestart |=> LINK_WORD == 16'h0000)
        else $error("single user not zero");
    a_soft_rst: assert property (@(posedge CLOCK) disable iff (!NRST)
        soft_rst |=> if_test_q == 8'h00)
        else $error("soft reset ignored");
    c_pn_long: cover property (@(posedge CLOCK) disable iff (!NRST)
        amode == otp_pkg::C_PNL ##3 amode == otp_pkg::C_PNL);
    c_user_rep: cover property (@(posedge CLOCK) disable iff (!NRST)
        imode == otp_pkg::I_UREP ##5 imode == otp_pkg::I_UREP);
    c_ddc_test: cover property (@(posedge CLOCK) disable iff (!NRST)
        atest && ddc_q[0][otp_pkg::B_DDC_TEST_Q]);
endmodule : otp_gen
`default_nettype wire

/* File: hdl/otp_pkg.sv */
// Purpose: constants and types for the output test pattern generator
// Assumes: 100 MHz encode-domain clock, classic Wishbone register access
// Notes: register map below
// What this block does
// - test mode disconnects core, feeds formatter
// - test register bits 4/5 reset the PN generators
// - analog ignored; encode clock still required
// - I takes channel A, Q channel B
// - fourth converter: I from A, no Q
// - codes 0-4: off, mid, +fs, -fs, checker
// - code 5: long 23-bit sequence, seed 3AFF
// - code 6: short 9-bit sequence, seed 092
// - code 7 toggle, code F ramp
// - code 8 repeat: user words bits 15:2
// - code 8 single: user words, then zeros
// - transport sample test sends raw samples
// - interface register: pattern and injection point
// - interface codes 1,2 alternate, 8 ramp
// - codes 3,4: 31- and 23-bit sequences
// - codes 5,6,7: 15-, 9-, 7-bit sequences
// - code E: user words repeating
// - code F: user words once, then zeros
// - point 00 sample, 01 ten-bit, 10 octet
package otp_pkg;
    // byte addresses on the register bus
    localparam logic [11:0] A_CONFIG = 12'h000;
    localparam logic [11:0] A_DDC0 = 12'h327;
    localparam logic [11:0] A_DDC1 = 12'h347;
    localparam logic [11:0] A_DDC2 = 12'h367;
    localparam logic [11:0] A_FOURTH_DOWN_CONVERTER = 12'h387;
    localparam logic [11:0] A_ADC_TEST = 12'h550;
    localparam logic [11:0] A_USER0 = 12'h551;
    localparam logic [11:0] A_USER7 = 12'h558;
    localparam logic [11:0] A_TPORT = 12'h571;
    localparam logic [11:0] A_IF_TEST = 12'h573;
    localparam logic [11:0] A_STATUS = 12'h600;
    localparam logic [7:0] SOFT_RESET_VAL = 8'h81;
    localparam int B_PN_RST_LO = 4;
    localparam int B_PN_RST_HI = 5;
    localparam int B_TPORT_EN = 5;
    localparam int B_USER_SINGLE = 7;
    localparam int B_DDC_TEST_I = 0;
    localparam int B_DDC_TEST_Q = 2;
    localparam logic [3:0] C_OFF = 4'h0;
    localparam logic [3:0] C_MID = 4'h1;
    localparam logic [3:0] C_PFS = 4'h2;
    localparam logic [3:0] C_NFS = 4'h3;
    localparam logic [3:0] C_CHK = 4'h4;
    localparam logic [3:0] C_PNL = 4'h5;
    localparam logic [3:0] C_PNS = 4'h6;
    localparam logic [3:0] C_TOG = 4'h7;
    localparam logic [3:0] C_USR = 4'h8;
    localparam logic [3:0] C_RMP = 4'hF;
    localparam logic [3:0] I_ALT = 4'h1;
    localparam logic [3:0] I_TOG = 4'h2;
    localparam logic [3:0] I_PN31 = 4'h3;
    localparam logic [3:0] I_PN23 = 4'h4;
    localparam logic [3:0] I_PN15 = 4'h5;
    localparam logic [3:0] I_PN9 = 4'h6;
    localparam logic [3:0] I_PN7 = 4'h7;
    localparam logic [3:0] I_RMP = 4'h8;
    localparam logic [3:0] I_UREP = 4'hE;
    localparam logic [3:0] I_USNG = 4'hF;
    localparam logic [30:0] SEED31 = 31'h0003AFFF;
    localparam logic [22:0] SEED23 = 23'h003AFF;
    localparam logic [14:0] SEED15 = 15'h03AF;
    localparam logic [8:0] SEED9 = 9'h092;
    localparam logic [6:0] SEED7 = 7'h07;
    typedef enum logic [1:0] {
        INJ_SAMPLE, INJ_TENBIT, INJ_OCTET, INJ_NONE
    } otp_inj_e;
    typedef struct packed {
        logic [13:0] i;
        logic [13:0] q;
    } otp_pair_s;
endpackage : otp_pkg

/* File: verification/otp_link_rx.sv */
// Purpose: far-side link receiver model for the test pattern generator
// Assumes: one word per encode clock while injection is flagged
// Notes: keeps a count so the bench can see when traffic stops
`timescale 1ns/1ps
`default_nettype none
module otp_link_rx (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // link words from the generator
    input wire logic inject,
    input wire logic [15:0] word,
    output logic [15:0] last_word,
    output logic [31:0] word_count
);
    ////////////////////////////////////////////////////////////////////////
    // one word taken per clock, never throttled, like a real lane
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            last_word <= 16'h0000;
            word_count <= 32'h0000_0000;
        end else if (inject) begin
            last_word <= word;
            word_count <= word_count + 32'h0000_0001;
        end
    end
endmodule : otp_link_rx
`default_nettype wire

/* File: verification/otp_gen_tb.sv */
// Purpose: self-checking bench for the output test pattern generator
// Assumes: one-cycle Wishbone ack; outputs sampled at rising edges
// Notes: first word of a stream lands two edges after the write's ack
`timescale 1ns/1ps
`default_nettype none
module otp_gen_tb;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [11:0] wb_adr = 12'h000;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0000_0000;
    logic [31:0] wb_rd, rdata;
    logic wb_ack, core_cut, link_inject, link_tport;
    otp_pkg::otp_pair_s core_in, adc_out;
    otp_pkg::otp_pair_s ddc_in [4];
    otp_pkg::otp_pair_s ddc_out [4];
    logic [15:0] link_word, rx_word;
    logic [1:0] link_point;
    logic [31:0] rx_count;
    logic [15:0] sq [8];
    int bad_count = 0;
    int samples_checked = 0;
    localparam logic [15:0] UW [4] = '{16'h1234, 16'hABCD, 16'h5678,
        16'hFEDC};
    localparam logic [15:0] MSK [3] = '{16'hFFFF, 16'h03FF, 16'h00FF};

    always #5 clock = ~clock;

    otp_gen otp_gen_inst (.CLOCK(clock), .NRST(nrst), .WB_CYC_I(wb_cyc),
        .WB_STB_I(wb_stb), .WB_WE_I(wb_we), .WB_ADR_I(wb_adr),
        .WB_SEL_I(wb_sel), .WB_DAT_I(wb_dat), .WB_DAT_O(wb_rd),
        .WB_ACK_O(wb_ack), .CORE_IN(core_in), .DDC_IN(ddc_in),
        .ADC_OUT(adc_out), .DDC_OUT(ddc_out), .CORE_CUT(core_cut),
        .LINK_WORD(link_word), .LINK_POINT(link_point),
        .LINK_INJECT(link_inject), .LINK_TPORT(link_tport));
    otp_link_rx otp_link_rx_inst (.clk(clock), .nrst(nrst),
        .inject(link_inject), .word(link_word), .last_word(rx_word),
        .word_count(rx_count));

    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // classic single cycle, held until ack is seen at a rising edge
    task automatic xfer(input logic we, input logic [11:0] a,
        input logic [7:0] d);
        int n;
        @(posedge clock);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= 4'h1;
        wb_dat <= {24'h000000, d};
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        if (n >= 20) check(32'h0000_0000, 32'h0000_0001);
        rdata = wb_rd;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask : xfer

    function automatic logic [15:0] cur(input int w);
        return (w == 0) ? {2'h0, adc_out.i} : link_word;
    endfunction : cur

    // restart lands the edge after the write, first word one edge later;
    // a free search could lock onto a stale word of the previous mode
    task automatic stream(input int w, input int n);
        int k;
        repeat (2) @(posedge clock);
        check(32'(cur(w)), 32'(sq[0]));
        for (k = 1; k < n; k++) begin
            @(posedge clock);
            check(32'(cur(w)), 32'(sq[k]));
            if (w == 0) check(32'(adc_out.q), 32'(adc_out.i));
        end
    endtask : stream

    task automatic soft_reset();
        xfer(1'b1, otp_pkg::A_CONFIG, otp_pkg::SOFT_RESET_VAL);
        repeat (3) @(posedge clock);
    endtask : soft_reset

    ////////////////////////////////////////////////////////////////////////
    task automatic t_idle();
        xfer(1'b0, otp_pkg::A_ADC_TEST, 8'h00);
        check(rdata, 32'h0000_0000);
        xfer(1'b1, 12'h100, 8'hFF);
        xfer(1'b0, 12'h100, 8'h00);
        check(rdata, 32'h0000_0000);
        repeat (2) @(posedge clock);
        check(32'(adc_out), 32'(core_in));
        check(32'({core_cut, link_inject}), 32'h0000_0000);
    endtask : t_idle

    task automatic t_fixed();
        logic [13:0] ev [3] = '{14'h0000, 14'h1FFF, 14'h2000};
        for (int c = 1; c < 4; c++) begin
            xfer(1'b1, otp_pkg::A_ADC_TEST, 8'(c));
            repeat (3) @(posedge clock);
            core_in <= '{i: 14'h3333, q: 14'h0F0F};
            repeat (2) @(posedge clock);
            check(32'(adc_out), 32'({ev[c-1], ev[c-1]}));
            check(32'(core_cut), 32'h0000_0001);
        end
    endtask : t_fixed

    task automatic t_cycle();
        for (int k = 0; k < 8; k++) sq[k] = k[0] ? 16'h2AAA : 16'h1555;
        xfer(1'b1, otp_pkg::A_ADC_TEST, 8'(otp_pkg::C_CHK));
        stream(0, 8);
        for (int k = 0; k < 8; k++) sq[k] = k[0] ? 16'h3FFF : 16'h0000;
        xfer(1'b1, otp_pkg::A_ADC_TEST, 8'(otp_pkg::C_TOG));
        stream(0, 8);
        for (int k = 0; k < 8; k++) sq[k] = 16'(k);
        xfer(1'b1, otp_pkg::A_ADC_TEST, 8'(otp_pkg::C_RMP));
        stream(0, 8);
    endtask : t_cycle

    task automatic t_user();
        for (int k = 0; k < 4; k++) begin
            xfer(1'b1, 12'(otp_pkg::A_USER0 + 2 * k), UW[k][7:0]);
            xfer(1'b1, 12'(otp_pkg::A_USER0 + 2 * k + 1), UW[k][15:8]);
        end
        for (int k = 0; k < 8; k++) sq[k] = {2'h0, UW[k % 4][15:2]};
        xfer(1'b1, otp_pkg::A_ADC_TEST, 8'h08);
        stream(0, 8);
        xfer(1'b1, otp_pkg::A_ADC_TEST, 8'h00);
        for (int k = 4; k < 8; k++) sq[k] = 16'h0000;
        xfer(1'b1, otp_pkg::A_ADC_TEST, 8'h88);
        stream(0, 8);
        for (int k = 0; k < 8; k++) sq[k] = UW[k % 4];
        xfer(1'b1, otp_pkg::A_IF_TEST, 8'(otp_pkg::I_UREP));
        stream(1, 8);
        for (int k = 4; k < 8; k++) sq[k] = 16'h0000;
        xfer(1'b1, otp_pkg::A_IF_TEST, 8'(otp_pkg::I_USNG));
        stream(1, 8);
        soft_reset();
    endtask : t_user

    task automatic t_pn();
        logic [15:0] w;
        for (int b = 0; b < 4; b++) begin
            xfer(1'b1, otp_pkg::A_ADC_TEST, b[0] ? 8'h16 : 8'h25);
            repeat (3) @(posedge clock);
            w = cur(0);
            repeat (4) @(posedge clock);
            check(32'(cur(0)), 32'(w));
            xfer(1'b1, otp_pkg::A_ADC_TEST, b[0] ? 8'h06 : 8'h05);
            repeat (2) @(posedge clock);
            w = cur(0);
            @(posedge clock);
            check(32'(cur(0) != w), 32'h0000_0001);
        end
        for (int c = 3; c < 8; c++) begin
            xfer(1'b1, otp_pkg::A_IF_TEST, 8'(c));
            repeat (3) @(posedge clock);
            w = link_word;
            @(posedge clock);
            check(32'(link_word != w), 32'h0000_0001);
            check(32'(link_inject), 32'h0000_0001);
        end
        soft_reset();
    endtask : t_pn

    task automatic t_link();
        int cnt;
        for (int p = 0; p < 3; p++) begin
            for (int k = 0; k < 8; k++) sq[k] = MSK[p] & (k[0] ? 16'hAAAA :
                16'h5555);
            xfer(1'b1, otp_pkg::A_IF_TEST, 8'(16 * p + 1));
            stream(1, 6);
            check(32'({link_inject, link_point}), 32'(4 + p));
            for (int k = 0; k < 8; k++) sq[k] = k[0] ? MSK[p] : 16'h0000;
            xfer(1'b1, otp_pkg::A_IF_TEST, 8'(16 * p + 2));
            stream(1, 6);
            for (int k = 0; k < 8; k++) sq[k] = 16'(k);
            xfer(1'b1, otp_pkg::A_IF_TEST, 8'(16 * p + 8));
            stream(1, 6);
        end
        check(32'(rx_word), 32'(link_word - 16'h0001));
        soft_reset();
        cnt = rx_count;
        repeat (4) @(posedge clock);
        check(rx_count, 32'(cnt));
        check(32'({core_cut, link_inject}), 32'h0000_0000);
        xfer(1'b0, otp_pkg::A_IF_TEST, 8'h00);
        check(rdata, 32'h0000_0000);
        xfer(1'b1, otp_pkg::A_TPORT, 8'h20);
        repeat (2) @(posedge clock);
        check(32'(link_tport), 32'h0000_0001);
        xfer(1'b1, otp_pkg::A_TPORT, 8'h00);
        repeat (2) @(posedge clock);
        check(32'(link_tport), 32'h0000_0000);
    endtask : t_link

    task automatic t_ddc();
        xfer(1'b1, otp_pkg::A_DDC0, 8'h05);
        xfer(1'b1, otp_pkg::A_FOURTH_DOWN_CONVERTER, 8'h05);
        xfer(1'b1, otp_pkg::A_ADC_TEST, 8'(otp_pkg::C_PFS));
        repeat (3) @(posedge clock);
        check(32'(ddc_out[0]), 32'({14'h1FFF, 14'h1FFF}));
        check(32'(ddc_out[3]), 32'({14'h1FFF, ddc_in[3].q}));
        check(32'(ddc_out[1]), 32'(ddc_in[1]));
        soft_reset();
    endtask : t_ddc

    ////////////////////////////////////////////////////////////////////////
    initial begin
        core_in = '{i: 14'h0ABC, q: 14'h1234};
        for (int k = 0; k < 4; k++) begin
            ddc_in[k] = '{i: 14'h0100 + 14'(k), q: 14'h0200 + 14'(k)};
        end
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        t_idle();
        t_fixed();
        t_cycle();
        t_user();
        t_pn();
        t_link();
        t_ddc();
        end_of_test();
    end

    // budget is about fifty times the expected run length
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        end_of_test();
    end
endmodule : otp_gen_tb
`default_nettype wire
